/* File: hw/cmos_out_map.vh */
// Register offsets, field positions, reset values and field masks for the
// serial CMOS output format block.
// Assumes an 8-bit register port addressed by printed byte offsets.
`ifndef CMOS_OUT_MAP_VH
`define CMOS_OUT_MAP_VH

`define ADDR_IN_CLK_EN     8'h18
`define ADDR_FRAME_CTRL    8'h19
`define ADDR_MAPPER_CTRL   8'h1b
`define ADDR_CLK_DELAY     8'h1e
`define ADDR_CLK_BUF_CTRL  8'h1f
`define ADDR_PAT_LOW       8'h20
`define ADDR_PAT_MID       8'h21
`define ADDR_PAT_HIGH      8'h22
`define ADDR_STATUS        8'h2f

`define MASK_IN_CLK_EN     8'h10
`define MASK_FRAME_CTRL    8'h93
`define MASK_MAPPER_CTRL   8'hf8
`define MASK_CLK_DELAY     8'h30
`define MASK_CLK_BUF_CTRL  8'hd8
`define MASK_PAT_HIGH      8'h0f

`define RST_IN_CLK_EN      8'h00
`define RST_FRAME_CTRL     8'h00
`define RST_MAPPER_CTRL    8'h00
`define RST_CLK_DELAY      8'h00
`define RST_CLK_BUF_CTRL   8'h10
`define RST_PAT_LOW        8'h00
`define RST_PAT_MID        8'hfc
`define RST_PAT_HIGH       8'h0f

`define BIT_IN_CLK_EN      4
`define BIT_FRAME_SRC      7
`define BIT_FRAME_DIV      4
`define BIT_FRAME_PIN      1
`define BIT_FRAME_TOG      0
`define BIT_MAPPER_EN      7
`define BIT_WIDE_EN        6
`define RES_HI             5
`define RES_LO             3
`define DEL_HI             5
`define DEL_LO             4
`define BIT_LOW_DRIVE      7
`define BIT_IN_CLK_EN2     6
`define BIT_OUT_BUF_EN     4
`define BIT_SINGLE_EDGE    3

`define RES_CODE_18        3'b000
`define RES_CODE_16        3'b001
`define RES_CODE_14        3'b010
`define RES_BITS_20        5'd20
`define RES_BITS_18        5'd18
`define RES_BITS_16        5'd16
`define RES_BITS_14        5'd14
`define RES_BITS_NATIVE    5'd14

`define MODE_BYPASS        2'b00
`define MODE_REAL          2'b01
`define MODE_COMPLEX       2'b10

`define PAT_ALL_ONES       20'hfffff

`endif

/* File: hw/link_clock_sync.v */
// Two-flop synchroniser with edge detection for the incoming data clock.
// Assumes the link clock is far slower than core_clk (at least 4x).
`timescale 1ns/1ps
`default_nettype none
module link_clock_sync (
  input  wire core_clk,
  input  wire rst_b,
  input  wire async_in,
  output reg  level,
  output wire rise,
  output wire fall
);
  reg meta_r;
  reg prev_r;

  // Only the second stage may look at the first one
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      meta_r <= 1'b0;
      level  <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      level  <= meta_r;
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;
endmodule
`default_nettype wire

/* File: hw/serial_cmos_output_format_config.v */
// Serial CMOS output format: configuration registers, resolution mapper,
// frame clock pattern generation and a lane serialiser paced by the
// incoming data clock.
// Assumes sample words arrive MSB aligned and stable on core_clk, and
// that the incoming data clock is asynchronous and much slower.
`timescale 1ns/1ps
`default_nettype none
`include "cmos_out_map.vh"
module serial_cmos_output_format_config (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [1:0]  decimation_mode,
  input  wire [19:0] conv_word_a,
  input  wire [19:0] conv_word_b,
  input  wire [19:0] dec_word_a,
  input  wire [19:0] dec_word_b,
  input  wire        parallel_bit,
  input  wire        input_data_clock,
  output reg  [7:0]  reg_rdata,
  output reg  [1:0]  data_a,
  output reg  [1:0]  data_b,
  output reg         frame_clock_pin,
  output reg         output_data_clock,
  output reg         input_data_clock_buffer_enable,
  output reg         output_clock_buffer_enable,
  output reg  [1:0]  output_clock_delay_select,
  output reg         low_drive_enable
);

  // Returns {supported, resolution in bits}
  function [5:0] res_decode;
    input [2:0] code;
    begin
      case (code)
        `RES_CODE_18: res_decode = {1'b1, `RES_BITS_18};
        `RES_CODE_16: res_decode = {1'b1, `RES_BITS_16};
        `RES_CODE_14: res_decode = {1'b1, `RES_BITS_14};
        default:      res_decode = {1'b0, `RES_BITS_18};
      endcase
    end
  endfunction

  reg  [7:0]  in_clk_en_r;
  reg  [7:0]  frame_ctrl_r;
  reg  [7:0]  mapper_ctrl_r;
  reg  [7:0]  clk_delay_r;
  reg  [7:0]  clk_buf_ctrl_r;
  reg  [7:0]  pat_low_r;
  reg  [7:0]  pat_mid_r;
  reg  [7:0]  pat_high_r;
  reg  [7:0]  rdata_nxt;

  wire        lvl;
  wire        lvl_rise;
  wire        lvl_fall;

  wire        frame_clock_source;
  wire        frame_clock_divide;
  wire        frame_clock_toggle_half_wire;
  wire        frame_clock_pin_enable;
  wire        wide_output_enable;
  wire        mapper_enable;
  wire [2:0]  mapper_resolution_select;
  wire        single_edge_double_rate_clock;
  wire [19:0] frame_clock_pattern;
  wire        bypass;
  wire [5:0]  map_dec;

  reg  [4:0]  res_bits;
  reg  [5:0]  frame_len;
  reg  [19:0] pat_eff;
  reg  [19:0] word_a_sel;
  reg  [19:0] word_b_sel;

  reg  [19:0] sh_a_r;
  reg  [19:0] sh_b_r;
  reg  [19:0] pat_sh_r;
  reg  [5:0]  cnt_r;
  reg         half_b_r;
  reg         half_rate_r;
  reg         step;
  reg         frame_clock;

  link_clock_sync u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (input_data_clock),
    .level    (lvl),
    .rise     (lvl_rise),
    .fall     (lvl_fall)
  );

  assign frame_clock_source            = frame_ctrl_r[`BIT_FRAME_SRC];
  assign frame_clock_divide            = frame_ctrl_r[`BIT_FRAME_DIV];
  assign frame_clock_toggle_half_wire  = frame_ctrl_r[`BIT_FRAME_TOG];
  assign frame_clock_pin_enable        = frame_ctrl_r[`BIT_FRAME_PIN];
  assign wide_output_enable            = mapper_ctrl_r[`BIT_WIDE_EN];
  assign mapper_enable                 = mapper_ctrl_r[`BIT_MAPPER_EN];
  assign mapper_resolution_select      = mapper_ctrl_r[`RES_HI:`RES_LO];
  assign single_edge_double_rate_clock = clk_buf_ctrl_r[`BIT_SINGLE_EDGE];
  assign frame_clock_pattern = {pat_high_r[3:0], pat_mid_r, pat_low_r};
  assign bypass  = (decimation_mode == `MODE_BYPASS);
  assign map_dec = res_decode(mapper_resolution_select);

  // Register writes; reserved bits are not stored and read back as zero
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      in_clk_en_r    <= `RST_IN_CLK_EN;
      frame_ctrl_r   <= `RST_FRAME_CTRL;
      mapper_ctrl_r  <= `RST_MAPPER_CTRL;
      clk_delay_r    <= `RST_CLK_DELAY;
      clk_buf_ctrl_r <= `RST_CLK_BUF_CTRL;
      pat_low_r      <= `RST_PAT_LOW;
      pat_mid_r      <= `RST_PAT_MID;
      pat_high_r     <= `RST_PAT_HIGH;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_IN_CLK_EN:    in_clk_en_r    <= reg_wdata & `MASK_IN_CLK_EN;
        `ADDR_FRAME_CTRL:   frame_ctrl_r   <= reg_wdata & `MASK_FRAME_CTRL;
        `ADDR_MAPPER_CTRL:  mapper_ctrl_r  <= reg_wdata & `MASK_MAPPER_CTRL;
        `ADDR_CLK_DELAY:    clk_delay_r    <= reg_wdata & `MASK_CLK_DELAY;
        `ADDR_CLK_BUF_CTRL: clk_buf_ctrl_r <= reg_wdata & `MASK_CLK_BUF_CTRL;
        `ADDR_PAT_LOW:      pat_low_r      <= reg_wdata;
        `ADDR_PAT_MID:      pat_mid_r      <= reg_wdata;
        `ADDR_PAT_HIGH:     pat_high_r     <= reg_wdata & `MASK_PAT_HIGH;
        default:            ;
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero
  always @*
  begin
    case (reg_addr)
      `ADDR_IN_CLK_EN:    rdata_nxt = in_clk_en_r;
      `ADDR_FRAME_CTRL:   rdata_nxt = frame_ctrl_r;
      `ADDR_MAPPER_CTRL:  rdata_nxt = mapper_ctrl_r;
      `ADDR_CLK_DELAY:    rdata_nxt = clk_delay_r;
      `ADDR_CLK_BUF_CTRL: rdata_nxt = clk_buf_ctrl_r;
      `ADDR_PAT_LOW:      rdata_nxt = pat_low_r;
      `ADDR_PAT_MID:      rdata_nxt = pat_mid_r;
      `ADDR_PAT_HIGH:     rdata_nxt = pat_high_r;
      `ADDR_STATUS:
        rdata_nxt = {~map_dec[5], input_data_clock_buffer_enable,
                     1'b0, res_bits};
      default:            rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 8'h00;
  end

  // Effective resolution. Decimated paths honour the code field unless the
  // wide output bit forces 20 bits; an unsupported code falls back to 18 bits and is flagged in status.
  always @*
  begin
    if (wide_output_enable)
      res_bits = `RES_BITS_20;
    else if (!bypass)
      res_bits = map_dec[4:0];
    else if (mapper_enable)
      res_bits = map_dec[4:0];
    else
      res_bits = `RES_BITS_NATIVE;
  end

  // In bypass the pattern is rebuilt so half of the word is high
  always @*
  begin
    if (bypass)
      pat_eff = ~(`PAT_ALL_ONES >> res_bits[4:1]);
    else
      pat_eff = frame_clock_pattern;
  end

  // Shift steps per frame for each wire count
  always @*
  begin
    if (frame_clock_divide)
      frame_len = {2'b00, res_bits[4:1]};
    else if (frame_clock_toggle_half_wire)
      frame_len = {res_bits, 1'b0};
    else
      frame_len = {1'b0, res_bits};
  end

  always @*
  begin
    if (frame_clock_source)
    begin
      word_a_sel = dec_word_a;
      word_b_sel = dec_word_b;
    end
    else
    begin
      word_a_sel = conv_word_a;
      word_b_sel = conv_word_b;
    end
  end

  // Serial pacing: both input clock edges, or only the edges that
  // raise the halved output clock in single-edge mode
  always @*
  begin
    if (!input_data_clock_buffer_enable)
      step = 1'b0;
    else if (single_edge_double_rate_clock)
      step = lvl_rise & ~half_rate_r;
    else
      step = lvl_rise | lvl_fall;
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
      half_rate_r <= 1'b0;
    else if (!input_data_clock_buffer_enable)
      half_rate_r <= 1'b0;
    else if (lvl_rise)
      half_rate_r <= ~half_rate_r;
  end

  // Serialiser; a new word and pattern load when the frame wraps
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cnt_r    <= 6'd0;
      sh_a_r   <= 20'h00000;
      sh_b_r   <= 20'h00000;
      pat_sh_r <= 20'h00000;
      half_b_r <= 1'b0;
    end
    else if (step)
    begin
      if (cnt_r >= frame_len - 6'd1)
      begin
        cnt_r    <= 6'd0;
        sh_a_r   <= word_a_sel;
        sh_b_r   <= word_b_sel;
        pat_sh_r <= pat_eff;
        half_b_r <= 1'b0;
      end
      else
      begin
        cnt_r <= cnt_r + 6'd1;
        if (frame_clock_divide)
        begin
          sh_a_r   <= {sh_a_r[17:0], 2'b00};
          sh_b_r   <= {sh_b_r[17:0], 2'b00};
          pat_sh_r <= {pat_sh_r[17:0], 2'b00};
        end
        else if (frame_clock_toggle_half_wire)
        begin
          // Channel B waits untouched until channel A has gone out
          if (half_b_r)
            sh_b_r <= {sh_b_r[18:0], 1'b0};
          else
            sh_a_r <= {sh_a_r[18:0], 1'b0};
          pat_sh_r <= {pat_sh_r[18:0], 1'b0};
          if (cnt_r == {1'b0, res_bits} - 6'd1)
            half_b_r <= 1'b1;
        end
        else
        begin
          sh_a_r   <= {sh_a_r[18:0], 1'b0};
          sh_b_r   <= {sh_b_r[18:0], 1'b0};
          pat_sh_r <= {pat_sh_r[18:0], 1'b0};
        end
      end
    end
  end

  // Half-wire frame clock stays low while channel B is on the wire
  always @*
  begin
    if (frame_clock_toggle_half_wire)
      frame_clock = pat_sh_r[19] & ~half_b_r;
    else
      frame_clock = pat_sh_r[19];
  end

  // Pin and pad controls, all registered
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      data_a                         <= 2'b00;
      data_b                         <= 2'b00;
      frame_clock_pin                <= 1'b0;
      output_data_clock              <= 1'b0;
      input_data_clock_buffer_enable <= 1'b0;
      output_clock_buffer_enable     <= 1'b1;
      output_clock_delay_select      <= 2'b00;
      low_drive_enable               <= 1'b0;
    end
    else
    begin
      if (frame_clock_toggle_half_wire)
      begin
        data_a <= {half_b_r ? sh_b_r[19] : sh_a_r[19], 1'b0};
        data_b <= 2'b00;
      end
      else
      begin
        data_a <= {sh_a_r[19], frame_clock_divide & sh_a_r[18]};
        data_b <= {sh_b_r[19], frame_clock_divide & sh_b_r[18]};
      end
      if (frame_clock_pin_enable)
        frame_clock_pin <= frame_clock;
      else
        frame_clock_pin <= parallel_bit;
      // A powered-down output buffer holds the clock pin low
      if (!clk_buf_ctrl_r[`BIT_OUT_BUF_EN])
        output_data_clock <= 1'b0;
      else if (single_edge_double_rate_clock)
        output_data_clock <= half_rate_r;
      else
        output_data_clock <= lvl & input_data_clock_buffer_enable;
      input_data_clock_buffer_enable <=
        in_clk_en_r[`BIT_IN_CLK_EN] & clk_buf_ctrl_r[`BIT_IN_CLK_EN2];
      output_clock_buffer_enable <= clk_buf_ctrl_r[`BIT_OUT_BUF_EN];
      output_clock_delay_select <= clk_delay_r[`DEL_HI:`DEL_LO];
      low_drive_enable <= clk_buf_ctrl_r[`BIT_LOW_DRIVE];
    end
  end

endmodule
`default_nettype wire

/* File: test/fmt_cfg_asserts.sv */
// Checker: register port timing and pad controls of the format block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fmt_cfg_asserts (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] data_a,
  input wire logic [1:0] data_b,
  input wire logic       output_data_clock,
  input wire logic       input_data_clock_buffer_enable,
  input wire logic       output_clock_buffer_enable,
  input wire logic [1:0] output_clock_delay_select,
  input wire logic       low_drive_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire w18 = reg_wr && reg_addr == 8'h18;
  wire w1e = reg_wr && reg_addr == 8'h1e;
  wire w1f = reg_wr && reg_addr == 8'h1f;

  rd_idle_zero_a:
    assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  dly_readback_a:
    assert property (w1e ##1 !w1e ##1 reg_rd && reg_addr == 8'h1e
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'h30))
    else $error("delay register read back wrong");
  obuf_follow_a:
    assert property (w1f ##1 !w1f
      |=> output_clock_buffer_enable == $past(reg_wdata[4], 2))
    else $error("output clock buffer enable wrong");
  low_drive_a:
    assert property (w1f ##1 !w1f
      |=> low_drive_enable == $past(reg_wdata[7], 2))
    else $error("low drive enable wrong");
  dly_select_a:
    assert property (w1e ##1 !w1e
      |=> output_clock_delay_select == $past(reg_wdata[5:4], 2))
    else $error("clock delay select wrong");
  ibuf_off_a:
    assert property (w18 && !reg_wdata[4] ##1 !w18
      |=> !input_data_clock_buffer_enable)
    else $error("input buffer on with companion bit clear");
  reset_vals_a:
    assert property (disable iff (1'b0) !rst_b |=> output_clock_buffer_enable
      && !low_drive_enable && output_clock_delay_select == 2'h0)
    else $error("pad controls not at reset values");
  lanes_hold_a:
    assert property (!input_data_clock_buffer_enable [*4]
      |-> $stable(data_a) && $stable(data_b))
    else $error("lanes moved with input buffer off");
  clk_gated_a:
    assert property (!output_clock_buffer_enable [*2] |-> !output_data_clock)
    else $error("output clock active with buffer off");
endmodule

bind serial_cmos_output_format_config fmt_cfg_asserts chk_u (
  .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .data_a, .data_b, .output_data_clock, .input_data_clock_buffer_enable,
  .output_clock_buffer_enable, .output_clock_delay_select, .low_drive_enable
);
`default_nettype wire

/* File: test/fmt_rx_model.sv */
// Receiving capture logic: makes the data clock and watches lane A.
// Assumes the bench raises run only while a burst of frames is wanted.
`timescale 1ns/1ps
`default_nettype none
module fmt_rx_model (
  input  wire logic       core_clk,
  input  wire logic       run,
  input  wire logic [1:0] data_a,
  input  wire logic       output_data_clock,
  input  wire logic       frame_clock_pin,
  output var  logic       input_data_clock,
  output var  int         chg_cnt,
  output var  int         fall_chg,
  output var  int         rise_cnt,
  output var  int         frame_cnt
);
  logic d_q = 1'h0;
  logic c_q = 1'h0;
  logic c_q2 = 1'h0;
  logic f_q = 1'h0;
  initial input_data_clock = 1'h0;
  // 160 ns period; stands still low between bursts
  always #80
    if (run || input_data_clock)
      input_data_clock = ~input_data_clock;
  // Lanes may trail the forwarded clock by one core cycle, so a change
  // is paired with a clock fall seen up to two samples back
  always @(posedge core_clk)
  begin
    d_q <= data_a[1];
    c_q <= output_data_clock;
    c_q2 <= c_q;
    f_q <= frame_clock_pin;
    if (data_a[1] !== d_q)
    begin
      chg_cnt <= chg_cnt + 1;
      if (c_q2 && !output_data_clock)
        fall_chg <= fall_chg + 1;
    end
    if (!f_q && frame_clock_pin)
      frame_cnt <= frame_cnt + 1;
    if (!c_q && output_data_clock)
      rise_cnt <= rise_cnt + 1;
  end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Bench for the serial CMOS output format block with a link partner.
// Assumes the design header is on the include path; 100 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`include "cmos_out_map.vh"
module tb_top;
  logic        core_clk = 1'h0;
  logic        rst_b = 1'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [1:0]  decimation_mode = 2'h0;
  logic [19:0] conv_word_a = 20'haaaaa;
  logic [19:0] conv_word_b = 20'h00000;
  logic [19:0] dec_word_a = 20'h00000;
  logic [19:0] dec_word_b = 20'h00000;
  logic        parallel_bit = 1'h0;
  logic        run = 1'h0;
  logic        rd_seen = 1'h0;
  logic        b;
  logic [7:0]  v;
  logic [7:0]  exp_q[$];
  wire         input_data_clock;
  wire  [7:0]  reg_rdata;
  wire  [1:0]  data_a, data_b, output_clock_delay_select;
  wire         frame_clock_pin, output_data_clock, low_drive_enable;
  wire         input_data_clock_buffer_enable, output_clock_buffer_enable;
  int          chg_cnt, fall_chg, rise_cnt, dc, df, dr;
  int          frame_cnt, fr;
  int          error_cnt = 0;
  int          check_count = 0;
  // {offset, stored bits, reset value}
  logic [23:0] map[8] = '{24'h181000, 24'h199300, 24'h1bf800, 24'h1e3000,
                          24'h1fd810, 24'h20ff00, 24'h21fffc, 24'h220f0f};
  // {mode, mapper control, expected status}
  logic [23:0] res[10] = '{24'h008012, 24'h008810, 24'h00900e, 24'h009892,
                           24'h00080e, 24'h004014, 24'h010810, 24'h02100e,
                           24'h010012, 24'h020012};

  serial_cmos_output_format_config dut_u (
    .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .decimation_mode, .conv_word_a, .conv_word_b, .dec_word_a, .dec_word_b,
    .parallel_bit, .input_data_clock, .reg_rdata, .data_a, .data_b,
    .frame_clock_pin, .output_data_clock, .input_data_clock_buffer_enable,
    .output_clock_buffer_enable, .output_clock_delay_select,
    .low_drive_enable
  );
  fmt_rx_model rx_u (
    .core_clk, .run, .data_a, .output_data_clock, .input_data_clock,
    .chg_cnt, .fall_chg, .rise_cnt, .frame_clock_pin, .frame_cnt
  );

  initial
    forever #5 core_clk = ~core_clk;

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    if (rd_seen)
      chk(exp_q.pop_front(), reg_rdata);
    rd_seen <= reg_rd;
  end

  task automatic burst;
    int c0, f0, r0, n0;
    c0 = chg_cnt;
    f0 = fall_chg;
    r0 = rise_cnt;
    n0 = frame_cnt;
    run <= 1'h1;
    repeat (640) @(posedge core_clk);
    run <= 1'h0;
    repeat (40) @(posedge core_clk);
    dc = chg_cnt - c0;
    df = fall_chg - f0;
    dr = rise_cnt - r0;
    fr = frame_cnt - n0;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #200000;
    error_cnt++;
    end_of_test;
  end

  initial
  begin
    void'($urandom(51));
    repeat (8) @(posedge core_clk);
    rst_b <= 1'h1;
    conv_word_b <= 20'($urandom);
    dec_word_a <= 20'($urandom);
    dec_word_b <= 20'($urandom);
    foreach (map[i])
      rd(map[i][23:16], map[i][7:0]);
    $display("test reset values done");
    // Random values go to defined fields only; reserved bits stay zero
    foreach (map[i])
    begin
      v = 8'($urandom) & map[i][15:8];
      wr(map[i][23:16], v);
      rd(map[i][23:16], v);
    end
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    $display("test register access done");
    wr(8'h18, 8'h00);
    foreach (res[i])
    begin
      decimation_mode <= res[i][17:16];
      wr(8'h1b, res[i][15:8]);
      rd(`ADDR_STATUS, res[i][7:0]);
    end
    $display("test resolution done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h1e, {2'h0, 2'(i), 4'h0});
      wr(8'h18, {3'h0, i[1], 4'h0});
      wr(8'h1f, {i[1], i[0], 1'h0, ~i[0], 4'h0});
      repeat (3) @(posedge core_clk);
      chk({6'h0, 2'(i)}, {6'h0, output_clock_delay_select});
      chk({7'h0, i[1]}, {7'h0, low_drive_enable});
      chk({7'h0, i[0] & i[1]}, {7'h0, input_data_clock_buffer_enable});
      chk({7'h0, ~i[0]}, {7'h0, output_clock_buffer_enable});
    end
    $display("test pad controls done");
    decimation_mode <= 2'h0;
    wr(8'h19, 8'h00);
    repeat (2) @(posedge core_clk);
    repeat (8)
    begin
      b = 1'($urandom);
      parallel_bit <= b;
      repeat (2) @(posedge core_clk);
      chk({7'h0, b}, {7'h0, frame_clock_pin});
    end
    $display("test parallel pin done");
    wr(8'h1b, 8'h90);
    wr(8'h19, 8'h02);
    wr(8'h1f, 8'h50);
    wr(8'h18, 8'h00);
    burst();
    chk(8'h00, 8'(dc));
    wr(8'h18, 8'h10);
    burst();
    chk(8'h01, {7'h0, df > 10});
    chk(8'h01, {7'h0, dr > 30});
    // 14-bit 1-wire frames of 14 steps, about 80 steps in a burst
    chk(8'h01, {7'h0, fr >= 4 && fr <= 6});
    wr(8'h1f, 8'h58);
    burst();
    chk(8'h00, 8'(df));
    chk(8'h01, {7'h0, dc > 5 && dr > 10 && dr <= 25});
    $display("test link clocking done");
    repeat (4) @(posedge core_clk);
    end_of_test;
  end
endmodule
`default_nettype wire
